// ### logic/spi_flash_register_access.sv
// serial flash register access: status, configuration and bank register commands over the link
`timescale 1ns/1ns
`include "spi_flash_regs_map.svh"

// Function
// - command 05h returns status one anytime, refreshed every eight clocks.
// - command 07h returns status two anytime, refreshed every eight clocks.
// - command 35h returns configuration anytime, repeated every eight clocks.
// - command 16h shifts out the bank register repeatedly every eight clocks.
// - command 17h loads bank register from next byte without write enable.
// - bank bit 7 clear means three-byte commands take high address from bank.
// - bank writes leave error and write-in-progress bits untouched.
// - after B9h, write-registers loads only bank bits 1:0, no write enable.
// - that sequence closes bank access and never changes bank bit 7.
// - any other command or chip-select cycle after B9h closes bank access.
// - prefix plus write-registers only when idle or suspended and no errors.
// - write-registers without the B9h prefix accepted only with write-enable latch set.
// - eight data bits write status one, sixteen write both, else abort.
// - chip-select rise starts timed write; busy bit set, then latch cleared.
// - a failed register write sets the program or erase error flag.
// - write-disable bit clear allows writes with latch set, any pin level.
// - write-disable set and protect pin low rejects register writes.
// - region chosen by block-protect bits rejects program and erase.
// - hardware lock follows last of disable set or pin low; pin high releases.
// - write-enable command 06h sets status one bit 1.
// - four-bit mode disables protect-pin hardware protection.
module spi_flash_register_access #(
  parameter int ADDR_W = 25,
  parameter int WRR_CYCLES = `WRR_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_sck,
  input wire logic i_csn,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_wp_n,
  input wire logic i_array_busy,
  input wire logic i_prog_suspend,
  input wire logic i_erase_suspend,
  input wire logic i_fail_program,
  input wire logic i_fail_erase,
  input wire logic [ADDR_W-1:0] i_op_addr,
  output logic o_op_protected,
  output logic o_ext_addr_en,
  output logic [6:0] o_high_address
);

  localparam int TMR_W = $clog2(WRR_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(WRR_CYCLES);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(1);

  // the protect decode looks at seven top address bits, the timer needs two states at least
  generate
    if (ADDR_W < 8 || ADDR_W > 32 || WRR_CYCLES < 2)
    begin : g_bad_params
      $error("spi_flash_register_access: unsupported ADDR_W or WRR_CYCLES");
    end
  endgenerate

  // selects the byte a read command returns; zero for anything else
  function automatic logic [7:0] read_byte(input logic [7:0] cmd, input spi_flash_regs_pkg::readback_t rb);
    logic [7:0] r;
    r = 8'h00;
    if (cmd == `CMD_READ_STATUS_ONE)
      r = rb.sr1;
    else if (cmd == `CMD_READ_STATUS_TWO)
      r = rb.sr2;
    else if (cmd == `CMD_READ_CONFIG)
      r = rb.cfg;
    else if (cmd == `CMD_BANK_READ)
      r = rb.bank;
    return r;
  endfunction

  function automatic logic is_read_cmd(input logic [7:0] cmd);
    return cmd == `CMD_READ_STATUS_ONE || cmd == `CMD_READ_STATUS_TWO ||
           cmd == `CMD_READ_CONFIG || cmd == `CMD_BANK_READ;
  endfunction

  // top fraction of the array guarded by the block-protect code; code 7 guards it all
  function automatic logic is_protected(input logic [ADDR_W-1:0] addr, input logic [2:0] bp);
    logic hit;
    hit = (bp != 3'h0);
    for (int i = 0; i < 7; i++)
    begin
      if (i < 7 - int'(bp))
        hit = hit & addr[ADDR_W-1-i];
    end
    return hit;
  endfunction

  // ---------------- link domain, clocked by the serial clock ----------------
  logic in_frame_q;
  logic frame_tog_q = 1'b0; // no reset reaches the link side, so the toggle starts from a known level
  logic [6:0] shift_q;
  logic [7:0] out_q;
  spi_flash_regs_pkg::frame_t frame_q;
  spi_flash_regs_pkg::frame_t frame_d;
  spi_flash_regs_pkg::readback_t rb_meta_q;
  spi_flash_regs_pkg::readback_t rb_sync_q;
  spi_flash_regs_pkg::readback_t rb_prev_q;
  spi_flash_regs_pkg::readback_t rb_hold_q;
  spi_flash_regs_pkg::readback_t readback_q;

  // frame marker, cleared by chip select itself since no clock edge follows a frame
  always_ff @(posedge i_sck or posedge i_csn)
  begin
    if (i_csn)
      in_frame_q <= 1'b0;
    else
      in_frame_q <= 1'b1;
  end

  // the previous frame's counts stay visible until the first edge of the next one
  wire [2:0] bits_cur = in_frame_q ? frame_q.bits : 3'h0;
  wire [2:0] bytes_cur = in_frame_q ? frame_q.bytes : 3'h0;
  wire byte_done = (bits_cur == 3'h7);
  wire [7:0] byte_in = {shift_q, i_mosi};
  wire [2:0] bytes_inc = (byte_done && bytes_cur != `LEN_SAT) ? 3'(bytes_cur + 3'h1) : bytes_cur;

  // capture command and first two data bytes for the core domain
  always_comb
  begin
    frame_d = frame_q;
    frame_d.bits = 3'(bits_cur + 3'h1);
    frame_d.bytes = bytes_inc;
    if (!in_frame_q)
    begin
      frame_d.cmd = 8'h00;
      frame_d.data0 = 8'h00;
      frame_d.data1 = 8'h00;
    end
    if (byte_done && bytes_cur == 3'h0)
      frame_d.cmd = byte_in;
    if (byte_done && bytes_cur == 3'h1)
      frame_d.data0 = byte_in;
    if (byte_done && bytes_cur == 3'h2)
      frame_d.data1 = byte_in;
  end

  // input shifting on the rising edge; toggle announces a clocked frame to the core
  always_ff @(posedge i_sck)
  begin
    shift_q <= byte_in[6:0];
    frame_q <= frame_d;
    if (!in_frame_q)
      frame_tog_q <= ~frame_tog_q;
  end

  // two-flop crossing of the read-back image; a copy is kept only when two samples agree, so no torn word loads
  always_ff @(posedge i_sck)
  begin
    rb_meta_q <= readback_q;
    rb_sync_q <= rb_meta_q;
    rb_prev_q <= rb_sync_q;
    if (rb_sync_q == rb_prev_q)
      rb_hold_q <= rb_prev_q;
  end

  // output shifter on the falling edge, reloaded at each byte boundary so status stays fresh
  always_ff @(negedge i_sck or posedge i_csn)
  begin
    if (i_csn)
      out_q <= 8'h00;
    else if (frame_q.bits == 3'h0)
      out_q <= read_byte(frame_q.cmd, rb_hold_q);
    else
      out_q <= {out_q[6:0], 1'b0};
  end

  assign o_miso = out_q[7];
  assign o_miso_oe = in_frame_q && !i_csn && frame_q.bytes != 3'h0 && is_read_cmd(frame_q.cmd);

  // ---------------- core domain, clocked by the system clock ----------------
  logic csn_meta_q;
  logic csn_sync_q;
  logic csn_last_q;
  logic tog_meta_q;
  logic tog_sync_q;
  logic tog_seen_q;
  logic [1:0] warm_q;
  logic wp_meta_q;
  logic wp_sync_q;
  logic status_write_disable_q;
  logic perr_q;
  logic eerr_q;
  logic wel_q;
  logic [2:0] bp_q;
  logic [7:0] cfg_q;
  logic [7:0] bank_q;
  logic bank_access_prefix_open_q;
  logic [7:0] pend_sr1_q;
  logic [7:0] pend_cfg_q;
  logic pend_cfg_en_q;
  logic [TMR_W-1:0] timer_q;
  spi_flash_regs_pkg::wr_state_t state_q;

  // synchronisers for chip select, the frame toggle and the protect pin
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      csn_meta_q <= 1'b1;
      csn_sync_q <= 1'b1;
      csn_last_q <= 1'b1;
      tog_meta_q <= 1'b0;
      tog_sync_q <= 1'b0;
      wp_meta_q <= 1'b1;
      wp_sync_q <= 1'b1;
    end
    else
    begin
      csn_meta_q <= i_csn;
      csn_sync_q <= csn_meta_q;
      csn_last_q <= csn_sync_q;
      tog_meta_q <= frame_tog_q;
      tog_sync_q <= tog_meta_q;
      wp_meta_q <= i_wp_n;
      wp_sync_q <= wp_meta_q;
    end
  end

  // fields read once chip select reads high; a short frame may miss every clock edge, so only a frame that flipped the toggle counts
  wire frame_end = csn_sync_q && !csn_last_q;
  wire clocked = (tog_sync_q != tog_seen_q);
  wire ended = csn_sync_q && clocked && warm_q == 2'h3;
  wire [7:0] cmd = frame_q.cmd;
  wire len_cmd = frame_q.bytes == `LEN_CMD_ONLY && frame_q.bits == 3'h0;
  wire len_one = frame_q.bytes == `LEN_ONE_DATA && frame_q.bits == 3'h0;
  wire len_two = frame_q.bytes == `LEN_TWO_DATA && frame_q.bits == 3'h0;
  wire busy_wr = (state_q == spi_flash_regs_pkg::WR_BUSY);
  wire write_in_progress = busy_wr || i_array_busy;
  wire quad = cfg_q[`CR_QUAD_BIT];
  wire hw_lock = status_write_disable_q && !wp_sync_q && !quad;
  wire fail_any = i_fail_program || i_fail_erase;

  // command decode at the end of each frame
  wire do_write_enable_cmd = ended && len_cmd && cmd == `CMD_WRITE_ENABLE && !write_in_progress;
  wire do_wrdi = ended && len_cmd && cmd == `CMD_WRITE_DISABLE && !write_in_progress;
  wire do_clsr = ended && len_cmd && cmd == `CMD_CLEAR_STATUS;
  wire do_bank_write_cmd = ended && (frame_q.bytes >= `LEN_ONE_DATA) && cmd == `CMD_BANK_WRITE;
  wire is_wrr = ended && cmd == `CMD_WRITE_REGISTERS && (len_one || len_two);
  wire wrr_ok = !write_in_progress && !perr_q && !eerr_q;
  wire do_wrr_bank = is_wrr && bank_access_prefix_open_q && wrr_ok;
  wire do_wrr = is_wrr && !bank_access_prefix_open_q && wel_q && !hw_lock && !write_in_progress;
  wire done = busy_wr && timer_q == TMR_LAST;

  // register update values; hardware sets of the error flags win over a clear
  wire wel_d = done ? 1'b0 : (do_write_enable_cmd ? 1'b1 : (do_wrdi ? 1'b0 : wel_q));
  wire perr_d = (done && i_fail_program) ? 1'b1 : (do_clsr ? 1'b0 : perr_q);
  wire eerr_d = (done && i_fail_erase) ? 1'b1 : (do_clsr ? 1'b0 : eerr_q);
  wire commit = done && !fail_any;
  wire status_write_disable_d = commit ? pend_sr1_q[`SR1_STATUS_WRITE_DISABLE_BIT] : status_write_disable_q;
  wire [2:0] bp_d = commit ? pend_sr1_q[`SR1_BP_LSB +: 3] : bp_q;
  wire [7:0] cfg_d = (commit && pend_cfg_en_q) ? pend_cfg_q : cfg_q;
  wire [7:0] bank_d = do_bank_write_cmd ? frame_q.data0 :
                      (do_wrr_bank ? {bank_q[7:2], frame_q.data0[1:0]} : bank_q);
  wire bank_access_prefix_d = (frame_end || ended) ?
                (ended && len_cmd && cmd == `CMD_BANK_ACCESS_PREFIX) : bank_access_prefix_open_q;

  // status and configuration register state
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      status_write_disable_q <= 1'(`SR1_RESET >> `SR1_STATUS_WRITE_DISABLE_BIT);
      perr_q <= 1'b0;
      eerr_q <= 1'b0;
      wel_q <= 1'b0;
      bp_q <= 3'h0;
      cfg_q <= `CR_RESET;
      bank_q <= `BAR_RESET;
      bank_access_prefix_open_q <= 1'b0;
      tog_seen_q <= 1'b0;
      warm_q <= 2'h0;
    end
    else
    begin
      status_write_disable_q <= status_write_disable_d;
      perr_q <= perr_d;
      eerr_q <= eerr_d;
      wel_q <= wel_d;
      bp_q <= bp_d;
      cfg_q <= cfg_d;
      bank_q <= bank_d;
      bank_access_prefix_open_q <= bank_access_prefix_d;
      if (ended || warm_q != 2'h3)
        tog_seen_q <= tog_sync_q; // adopt a toggle left over from before reset
      if (warm_q != 2'h3)
        warm_q <= 2'(warm_q + 2'h1);
    end
  end

  // self-timed write engine; new values land only when the write completes
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      state_q <= spi_flash_regs_pkg::WR_IDLE;
      timer_q <= '0;
      pend_sr1_q <= 8'h00;
      pend_cfg_q <= 8'h00;
      pend_cfg_en_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        spi_flash_regs_pkg::WR_IDLE:
        begin
          if (do_wrr)
          begin
            state_q <= spi_flash_regs_pkg::WR_BUSY;
            timer_q <= TMR_LOAD;
            pend_sr1_q <= frame_q.data0;
            pend_cfg_q <= frame_q.data1;
            pend_cfg_en_q <= len_two;
          end
        end
        spi_flash_regs_pkg::WR_BUSY:
        begin
          timer_q <= TMR_W'(timer_q - TMR_LAST);
          if (done)
            state_q <= spi_flash_regs_pkg::WR_IDLE;
        end
        default:
          state_q <= spi_flash_regs_pkg::WR_IDLE;
      endcase
    end
  end

  // read-back image; status two reports the suspend states
  wire [7:0] sr1 = {status_write_disable_q, perr_q, eerr_q, bp_q, wel_q, write_in_progress};
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      readback_q <= '0;
    else
      readback_q <= '{bank: bank_q, cfg: cfg_q, sr2: {6'h00, i_erase_suspend, i_prog_suspend}, sr1: sr1};
  end

  // array-side outputs: protection lookup and the upper address for three-byte commands
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      o_op_protected <= 1'b0;
      o_ext_addr_en <= 1'b0;
      o_high_address <= 7'h00;
    end
    else
    begin
      o_op_protected <= is_protected(i_op_addr, bp_q);
      o_ext_addr_en <= bank_q[`BAR_EXT_BIT];
      o_high_address <= bank_q[`BAR_EXT_BIT] ? 7'h00 : bank_q[6:0];
    end
  end

endmodule

// ### logic/spi_flash_regs_map.svh
// command codes, register bit positions, reset values and timing counts of the register access block
`ifndef SPI_FLASH_REGS_MAP_SVH
`define SPI_FLASH_REGS_MAP_SVH

// command codes
`define CMD_WRITE_REGISTERS 8'h01
`define CMD_WRITE_DISABLE 8'h04
`define CMD_READ_STATUS_ONE 8'h05
`define CMD_WRITE_ENABLE 8'h06
`define CMD_READ_STATUS_TWO 8'h07
`define CMD_BANK_READ 8'h16
`define CMD_BANK_WRITE 8'h17
`define CMD_CLEAR_STATUS 8'h30
`define CMD_READ_CONFIG 8'h35
`define CMD_BANK_ACCESS_PREFIX 8'hb9

// status register one bit positions
`define SR1_WIP_BIT 0
`define SR1_WEL_BIT 1
`define SR1_BP_LSB 2
`define SR1_EERR_BIT 5
`define SR1_PERR_BIT 6
`define SR1_STATUS_WRITE_DISABLE_BIT 7

// configuration and bank register bit positions
`define CR_QUAD_BIT 1
`define BAR_EXT_BIT 7

// reset values
`define SR1_RESET 8'h00
`define CR_RESET 8'h00
`define BAR_RESET 8'h00

// frame length in whole bytes as counted at the link
`define LEN_CMD_ONLY 3'h1
`define LEN_ONE_DATA 3'h2
`define LEN_TWO_DATA 3'h3
`define LEN_SAT 3'h4

// self-timed register write duration and the system clock period
`define WRR_TIME_NS 200000
`define MCLK_PERIOD_NS 100
`define WRR_CYCLES ((`WRR_TIME_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// ### logic/spi_flash_regs_pkg.sv
// types shared by the register access block
package spi_flash_regs_pkg;

  // one captured serial frame, handed from the link domain to the core domain
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data0;
    logic [7:0] data1;
    logic [2:0] bytes;
    logic [2:0] bits;
  } frame_t;

  // read-back image of all readable registers
  typedef struct packed {
    logic [7:0] bank;
    logic [7:0] cfg;
    logic [7:0] sr2;
    logic [7:0] sr1;
  } readback_t;

  // self-timed write engine states
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_BUSY = 2'b10
  } wr_state_t;

endpackage

// ### verification/spi_flash_register_access_properties.sv
// port-level assertions for the register access block
`timescale 1ns/1ns
module spi_flash_register_access_props #(
  parameter int ADDR_W = 25,
  parameter int WRR_CYCLES = 2000
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_sck,
  input wire logic i_csn,
  input wire logic i_mosi,
  input wire logic o_miso,
  input wire logic o_miso_oe,
  input wire logic i_wp_n,
  input wire logic i_array_busy,
  input wire logic i_prog_suspend,
  input wire logic i_erase_suspend,
  input wire logic i_fail_program,
  input wire logic i_fail_erase,
  input wire logic [ADDR_W-1:0] i_op_addr,
  input wire logic o_op_protected,
  input wire logic o_ext_addr_en,
  input wire logic [6:0] o_high_address
);
  logic [5:0] cnt_q;
  logic [7:0] cmd_q;
  wire is_read = cmd_q inside {8'h05, 8'h07, 8'h35, 8'h16};
  wire [7:0] bank_w = {o_ext_addr_en, o_high_address};
  // bits and command of the frame; saturating so long reads cannot wrap
  always_ff @(posedge i_sck or posedge i_csn)
  begin
    if (i_csn)
    begin
      cnt_q <= 6'h00;
      cmd_q <= 8'h00;
    end
    else
    begin
      if (cnt_q != 6'h3f) cnt_q <= cnt_q + 6'h01;
      if (cnt_q < 6'h08) cmd_q <= {cmd_q[6:0], i_mosi};
    end
  end
  property p_quiet_idle;
    @(posedge i_mclk) disable iff (!i_rstn) i_csn |-> !o_miso_oe;
  endproperty
  a_quiet_idle: assert property (p_quiet_idle) else $error("output driven while deselected");
  property p_quiet_cmd;
    @(posedge i_sck) disable iff (i_csn) cnt_q < 6'h08 |-> !o_miso_oe;
  endproperty
  a_quiet_cmd: assert property (p_quiet_cmd) else $error("output driven during command byte");
  property p_read_drives;
    @(posedge i_sck) disable iff (i_csn) cnt_q >= 6'h08 |-> o_miso_oe == is_read;
  endproperty
  a_read_drives: assert property (p_read_drives) else $error("output enable wrong for command");
  property p_bank_msb;
    @(posedge i_sck) disable iff (i_csn)
      cmd_q == 8'h16 && cnt_q >= 6'h08 && cnt_q[2:0] == 3'h0 |-> o_miso == o_ext_addr_en;
  endproperty
  a_bank_msb: assert property (p_bank_msb) else $error("bank bit 7 not first out");
  property p_bank_bits;
    @(posedge i_sck) disable iff (i_csn)
      cmd_q == 8'h16 && cnt_q >= 6'h08 && !o_ext_addr_en |-> o_miso == bank_w[~cnt_q[2:0]];
  endproperty
  a_bank_bits: assert property (p_bank_bits) else $error("bank read bit differs");
  property p_ext_high;
    @(posedge i_mclk) disable iff (!i_rstn) o_ext_addr_en |-> o_high_address == 7'h00;
  endproperty
  a_ext_high: assert property (p_ext_high) else $error("high address used with extended mode");
  property p_bank_frame;
    @(posedge i_mclk) disable iff (!i_rstn)
      !i_csn [*2] |-> $stable(o_high_address) && $stable(o_ext_addr_en);
  endproperty
  a_bank_frame: assert property (p_bank_frame) else $error("bank moved inside a frame");
  property p_reset_clean;
    @(posedge i_mclk) disable iff (!i_rstn)
      $rose(i_rstn) |-> !o_ext_addr_en && o_high_address == 7'h00 && !o_op_protected;
  endproperty
  a_reset_clean: assert property (p_reset_clean) else $error("outputs not clear after reset");
endmodule

// ### verification/spi_host_model.sv
// host side of the link: chip select, link clock and serial data out
`timescale 1ns/1ns
module spi_host_model #(
  parameter int HALF_NS = 3
) (
  output logic o_sck,
  output logic o_csn,
  output logic o_mosi,
  input wire logic i_miso,
  input wire logic i_miso_oe
);
  initial
  begin
    o_sck = 1'b0;
    o_csn = 1'b1;
    o_mosi = 1'b0;
  end
  // one frame of n bits from the top of tx; last 16 bits read back in rx
  // link clock stands low between frames, and the gap lets the core act
  task automatic xfer(input logic [31:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    #HALF_NS;
    o_csn = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      o_mosi = tx[31-i];
      #HALF_NS;
      rx = {rx[14:0], i_miso_oe ? i_miso : 1'bx};
      o_sck = 1'b1;
      #HALF_NS;
      o_sck = 1'b0;
    end
    #HALF_NS;
    o_csn = 1'b1;
    o_mosi = ~o_mosi; // a released line keeps no stale value
    #1000;
  endtask
endmodule

// ### verification/tb_spi_flash_register_access.sv
// self-checking bench for the register access block
`timescale 1ns/1ns
module tb_spi_flash_register_access;
  localparam int WR_CYC = 16;
  logic i_mclk, i_rstn, i_wp_n, i_array_busy, i_fail_program, i_fail_erase, i_prog_suspend, i_erase_suspend;
  logic sck, csn, mosi, miso, miso_oe, prot, ext;
  logic [24:0] i_op_addr;
  logic [6:0] high;
  logic [15:0] rx;
  int err_count, checks, cyc;
  spi_flash_register_access #(.ADDR_W(25), .WRR_CYCLES(WR_CYC)) DUT (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_sck(sck), .i_csn(csn), .i_mosi(mosi), .o_miso(miso),
    .o_miso_oe(miso_oe), .i_wp_n(i_wp_n), .i_array_busy(i_array_busy), .i_prog_suspend(i_prog_suspend),
    .i_erase_suspend(i_erase_suspend), .i_fail_program(i_fail_program), .i_fail_erase(i_fail_erase),
    .i_op_addr(i_op_addr),
    .o_op_protected(prot), .o_ext_addr_en(ext), .o_high_address(high));
  spi_host_model host (.o_sck(sck), .o_csn(csn), .o_mosi(mosi), .i_miso(miso), .i_miso_oe(miso_oe));
  initial
  begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] d, input int n);
    host.xfer({c, d, 8'h00}, n, rx);
  endtask
  // command byte, then the register byte twice to see it repeat
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    cmd(c, 16'h0000, 24);
    chk(rx, {e, e});
  endtask
  task automatic settle();
    repeat (WR_CYC + 10) @(posedge i_mclk);
  endtask
  // write enable first, then write-registers, then wait out the timed write
  task automatic write_registers_cmd(input logic [15:0] d, input int n);
    cmd(8'h06, 16'h0000, 8);
    cmd(8'h01, d, n);
    settle();
  endtask
  task automatic pin(input logic v);
    @(posedge i_mclk) i_wp_n <= v;
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic prot_at(input logic [24:0] a, input logic e);
    @(posedge i_mclk) i_op_addr <= a;
    repeat (3) @(posedge i_mclk);
    chk(16'(prot), 16'(e));
  endtask
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      wrap_up();
    end
  end
  initial
  begin
    {i_rstn, i_array_busy, i_fail_program, i_fail_erase, i_prog_suspend, i_erase_suspend, i_op_addr} = '0;
    i_wp_n = 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_mclk);
    rd(8'h05, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h35, 8'h00);
    rd(8'h16, 8'h00);
    $display("test reads done");
    // bank byte needs no write enable; high address follows until bit 7 is set
    cmd(8'h17, 16'h0300, 16);
    rd(8'h16, 8'h03);
    chk(16'({ext, high}), 16'h0003);
    cmd(8'h17, 16'h8000, 16);
    chk(16'({ext, high}), 16'h0080);
    $display("test bank done");
    cmd(8'h01, 16'h1c00, 16);
    settle();
    rd(8'h05, 8'h00);
    cmd(8'h06, 16'h0000, 8);
    rd(8'h05, 8'h02);
    cmd(8'h01, 16'h1c00, 16);
    rd(8'h05, 8'h03);
    settle();
    rd(8'h05, 8'h1c);
    prot_at(25'h0000000, 1'b1);
    write_registers_cmd(16'h9800, 24);
    rd(8'h05, 8'h98);
    rd(8'h35, 8'h00);
    prot_at(25'h0000000, 1'b0);
    prot_at(25'h1ffffff, 1'b1);
    $display("test write done");
    // lock refuses, pin high releases; four-bit mode ignores the pin
    pin(1'b0);
    write_registers_cmd(16'h0000, 16);
    rd(8'h05, 8'h9a);
    pin(1'b1);
    cmd(8'h01, 16'h8002, 24);
    settle();
    rd(8'h05, 8'h80);
    rd(8'h35, 8'h02);
    pin(1'b0);
    write_registers_cmd(16'h0002, 24);
    rd(8'h05, 8'h00);
    write_registers_cmd(16'h0000, 24);
    rd(8'h35, 8'h00);
    pin(1'b1);
    write_registers_cmd(16'h1c00, 20);
    rd(8'h05, 8'h02);
    cmd(8'h04, 16'h0000, 8);
    $display("test protect done");
    // prefix form loads bank bits 1:0 only and closes after one use
    cmd(8'hb9, 16'h0000, 8);
    cmd(8'h01, 16'hffff, 24);
    settle();
    rd(8'h16, 8'h83);
    cmd(8'h01, 16'h0000, 16);
    settle();
    rd(8'h16, 8'h83);
    cmd(8'hb9, 16'h0000, 8);
    rd(8'h05, 8'h00);
    write_registers_cmd(16'h0400, 16);
    rd(8'h05, 8'h04);
    rd(8'h16, 8'h83);
    $display("test prefix done");
    // failed write sets the error flag; bank write leaves it alone, and the prefix form is refused while it is set
    @(posedge i_mclk) i_fail_program <= 1'b1;
    write_registers_cmd(16'h1c00, 16);
    @(posedge i_mclk) i_fail_program <= 1'b0;
    rd(8'h05, 8'h44);
    cmd(8'h17, 16'h0100, 16);
    rd(8'h05, 8'h44);
    cmd(8'hb9, 16'h0000, 8);
    cmd(8'h01, 16'h0200, 16);
    settle();
    rd(8'h16, 8'h01);
    cmd(8'h30, 16'h0000, 8);
    rd(8'h05, 8'h04);
    @(posedge i_mclk) i_array_busy <= 1'b1;
    repeat (3) @(posedge i_mclk);
    rd(8'h05, 8'h05);
    // suspend states show in status two; an erase failure sets its own flag
    @(posedge i_mclk) {i_array_busy, i_erase_suspend} <= 2'b01;
    repeat (3) @(posedge i_mclk);
    rd(8'h07, 8'h02);
    @(posedge i_mclk) {i_erase_suspend, i_prog_suspend, i_fail_erase} <= 3'b011;
    write_registers_cmd(16'h1c00, 16);
    @(posedge i_mclk) i_fail_erase <= 1'b0;
    rd(8'h05, 8'h24);
    rd(8'h07, 8'h01);
    $display("test errors done");
    wrap_up();
  end
endmodule
bind spi_flash_register_access spi_flash_register_access_props #(.ADDR_W(ADDR_W), .WRR_CYCLES(WRR_CYCLES)) props (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_sck(i_sck), .i_csn(i_csn), .i_mosi(i_mosi), .o_miso(o_miso),
  .o_miso_oe(o_miso_oe), .i_wp_n(i_wp_n), .i_array_busy(i_array_busy), .i_prog_suspend(i_prog_suspend),
  .i_erase_suspend(i_erase_suspend), .i_fail_program(i_fail_program), .i_fail_erase(i_fail_erase),
  .i_op_addr(i_op_addr), .o_op_protected(o_op_protected), .o_ext_addr_en(o_ext_addr_en),
  .o_high_address(o_high_address));
